// ### pdm_defs.svh
// Register map, field positions and reset values of the pulse density modulator
// =====================================================================
// Function
// - The modulator clock is the master clock divided by 1, 2, 4 ... 128 as the 3-bit select code goes 0 to 7.
// - The modulator clock is split into sixteen streams, stream n running at that clock over 2 to the (16-n).
// - A channel output combines the streams whose index is a set bit of its 16-bit density word.
// - Any density word 0..65535 is accepted and gives an average duty of the word over 65536.
// - The output is never continuously high; for full duty software drives the pin as plain I/O.
// - Bit 4 of the port B mode register routes channel one onto port B pin 2 while the modulator is enabled, else plain I/O.
// - Bit 6 of the port B mode register routes a modulator output onto port B pin 5, else plain I/O.
// - A second 16-bit density word, in high and low bytes, selects streams the same way.
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// =====================================================================
// Register indices; the byte address is four times the index
`define PDM_IDX_PORT_B_MODE  8'h27
`define PDM_IDX_DENS1_HIGH   8'h30
`define PDM_IDX_DENS1_LOW    8'h31
`define PDM_IDX_DENS2_HIGH   8'h32
`define PDM_IDX_DENS2_LOW    8'h33
`define PDM_IDX_MOD_CTRL     8'h36

// =====================================================================
// Field positions and writable masks
`define PDM_BIT_PIN5_SEL     6
`define PDM_BIT_PIN2_SEL     4
`define PDM_BIT_MOD_EN       4
`define PDM_CSEL_MSB         2
`define PDM_MASK_PORT_B_MODE 8'h50
`define PDM_MASK_MOD_CTRL    8'h17

// =====================================================================
// Reset values
`define PDM_RST_BYTE         8'h00
`define PDM_RST_WORD         32'h0000_0000

`endif

// ### pdm_pkg.sv
// Types shared by the pulse density modulator files
`default_nettype none

package pdm_pkg;

  // =====================================================================
  // Bus slave states
  typedef enum logic [0:0] {
    PDM_IDLE = 1'b0,
    PDM_RESP = 1'b1
  } pdm_apb_state_type;

  typedef logic [2:0] pdm_div_code_type;

endpackage

`default_nettype wire

// ### pdm_clock_divider.sv
// Modulator clock tick generator, divide by two to the select code
`timescale 1ns/1ps
`default_nettype none

module pdm_clock_divider #(
  parameter int DIV_W = 3
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] code_i,
  // Modulator clock as a one-cycle tick
  output logic                  tick_o
);

  localparam int CW = (1 << DIV_W) - 1;

  generate
    if (DIV_W < 1 || DIV_W > 5) begin : g_check
      $error("pdm_clock_divider: DIV_W out of range");
    end
  endgenerate

  // Low counter bits, as many as the code, that must all be set for a tick
  function automatic logic [CW-1:0] low_mask(input logic [DIV_W-1:0] code);
    logic [CW-1:0] m;
    m = '0;
    for (int i = 0; i < CW; i++) begin
      m[i] = (i < int'(code));
    end
    return m;
  endfunction

  logic [CW-1:0] count;

  wire logic [CW-1:0] mask       = low_mask(code_i);
  wire logic [CW-1:0] next_count = count + CW'(1);

  assign tick_o = run_i && ((count & mask) == mask);

  // Held at zero while stopped so the first tick after enable is deterministic
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= '0;
    end else if (!run_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

// ### pdm_rate_mult.sv
// One binary rate multiplier channel
`timescale 1ns/1ps
`default_nettype none

module pdm_rate_mult #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Control
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] density_i,
  // Channel output and counter state
  output logic              pulse_o,
  output logic [W-1:0]      count_o
);

  generate
    if (W < 2) begin : g_check
      $error("pdm_rate_mult: W too small");
    end
  endgenerate

  wire logic [W-1:0] next_count = count_o + W'(1);
  // Exactly one counter bit rises per tick, except on wrap, so streams never overlap
  wire logic [W-1:0] rise_bit   = ~count_o & next_count;
  wire logic [W-1:0] dens_rev;

  // Counter bit k rises at tick rate over 2^(k+1), which is stream W-1-k
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_rev
      assign dens_rev[k] = density_i[W-1-k];
    end
  endgenerate

  wire logic fire = |(rise_bit & dens_rev);

  // Output holds for a whole modulator clock period, so duty is density over 2^W
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= '0;
      pulse_o <= 1'b0;
    end else if (!run_i) begin
      count_o <= '0;
      pulse_o <= 1'b0;
    end else if (tick_i) begin
      count_o <= next_count;
      pulse_o <= fire;
    end
  end

endmodule

`default_nettype wire

// ### pdm_modulator.sv
// Two-channel pulse density modulator with APB registers and port B pin routing
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defs.svh"

module pdm_modulator #(
  parameter int ADDR_W = 12,
  parameter int DENS_W = 16,
  parameter int DIV_W  = 3
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic                   pready_o,
  output logic [31:0]            prdata_o,
  output logic                   pslverr_o,
  // Port B plain I/O data from the port logic
  input  wire logic              gpio_pin2_i,
  input  wire logic              gpio_pin5_i,
  // Port B pin levels after the output multiplexer
  output logic                   pin2_o,
  output logic                   pin5_o
);

  generate
    if (ADDR_W < 10) begin : g_addr_check
      $error("pdm_modulator: ADDR_W must be at least 10");
    end
    if (DENS_W != 16 || DIV_W != 3) begin : g_width_check
      $error("pdm_modulator: register layout needs DENS_W 16 and DIV_W 3");
    end
  endgenerate

  // =====================================================================
  // Registers
  pdm_pkg::pdm_apb_state_type state;
  logic [7:0]                 port_b_mode;
  logic [7:0]                 density1_high;
  logic [7:0]                 density1_low;
  logic [7:0]                 density2_high;
  logic [7:0]                 density2_low;
  logic [7:0]                 modulator_control;

  // =====================================================================
  // Address decode
  wire logic [7:0] idx        = paddr_i[9:2];
  wire logic       upper_zero = (paddr_i[ADDR_W-1:10] == '0);
  wire logic       hit_mode   = upper_zero && (idx == `PDM_IDX_PORT_B_MODE);
  wire logic       hit_d1h    = upper_zero && (idx == `PDM_IDX_DENS1_HIGH);
  wire logic       hit_d1l    = upper_zero && (idx == `PDM_IDX_DENS1_LOW);
  wire logic       hit_d2h    = upper_zero && (idx == `PDM_IDX_DENS2_HIGH);
  wire logic       hit_d2l    = upper_zero && (idx == `PDM_IDX_DENS2_LOW);
  wire logic       hit_ctrl   = upper_zero && (idx == `PDM_IDX_MOD_CTRL);
  wire logic       hit_any    = hit_mode | hit_d1h | hit_d1l | hit_d2h | hit_d2l | hit_ctrl;

  // Writes land only on the edge where pready is seen high
  wire logic acc_req  = psel_i && penable_i;
  wire logic acc_done = acc_req && (state == pdm_pkg::PDM_RESP);
  wire logic wr_fire  = acc_done && pwrite_i && pstrb_i[0];

  wire logic [7:0] rd_byte =
      hit_mode ? port_b_mode :
      hit_d1h  ? density1_high :
      hit_d1l  ? density1_low :
      hit_d2h  ? density2_high :
      hit_d2l  ? density2_low :
      hit_ctrl ? modulator_control : `PDM_RST_BYTE;

  wire logic [31:0] next_prdata = pwrite_i ? `PDM_RST_WORD : {24'h00_0000, rd_byte};

  // =====================================================================
  // Control fields
  wire logic                     modulator_enable       = modulator_control[`PDM_BIT_MOD_EN];
  wire pdm_pkg::pdm_div_code_type modulator_clock_select = modulator_control[`PDM_CSEL_MSB:0];
  wire logic                     pin2_output_select     = port_b_mode[`PDM_BIT_PIN2_SEL];
  wire logic                     pin5_output_select     = port_b_mode[`PDM_BIT_PIN5_SEL];
  wire logic [DENS_W-1:0]        density_word_one       = {density1_high, density1_low};
  wire logic [DENS_W-1:0]        density_word_two       = {density2_high, density2_low};

  // =====================================================================
  // APB slave: one wait cycle, then pready with data
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= pdm_pkg::PDM_IDLE;
      pready_o  <= 1'b0;
      prdata_o  <= `PDM_RST_WORD;
      pslverr_o <= 1'b0;
    end else begin
      case (state)
        pdm_pkg::PDM_IDLE: begin
          if (acc_req) begin
            state     <= pdm_pkg::PDM_RESP;
            pready_o  <= 1'b1;
            prdata_o  <= next_prdata;
            pslverr_o <= !hit_any;
          end
        end
        pdm_pkg::PDM_RESP: begin
          state     <= pdm_pkg::PDM_IDLE;
          pready_o  <= 1'b0;
          prdata_o  <= `PDM_RST_WORD;
          pslverr_o <= 1'b0;
        end
        default: begin
          state    <= pdm_pkg::PDM_IDLE;
          pready_o <= 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // Register file; unimplemented bits stay zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_b_mode       <= `PDM_RST_BYTE;
      density1_high     <= `PDM_RST_BYTE;
      density1_low      <= `PDM_RST_BYTE;
      density2_high     <= `PDM_RST_BYTE;
      density2_low      <= `PDM_RST_BYTE;
      modulator_control <= `PDM_RST_BYTE;
    end else if (wr_fire) begin
      if (hit_mode) port_b_mode <= pwdata_i[7:0] & `PDM_MASK_PORT_B_MODE;
      if (hit_d1h) density1_high <= pwdata_i[7:0];
      if (hit_d1l) density1_low <= pwdata_i[7:0];
      if (hit_d2h) density2_high <= pwdata_i[7:0];
      if (hit_d2l) density2_low <= pwdata_i[7:0];
      if (hit_ctrl) modulator_control <= pwdata_i[7:0] & `PDM_MASK_MOD_CTRL;
    end
  end

  // =====================================================================
  // Modulator clock and the two channels
  wire  logic          tick;
  wire  logic [1:0]    chan_pulse;
  logic [DENS_W-1:0]   chan_count [2];
  wire  logic [DENS_W-1:0] chan_density [2];

  assign chan_density[0] = density_word_one;
  assign chan_density[1] = density_word_two;

  pdm_clock_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .run_i    (modulator_enable),
    .code_i   (modulator_clock_select),
    .tick_o   (tick)
  );

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      pdm_rate_mult #(
        .W (DENS_W)
      ) u_chan (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .run_i     (modulator_enable),
        .tick_i    (tick),
        .density_i (chan_density[c]),
        .pulse_o   (chan_pulse[c]),
        .count_o   (chan_count[c])
      );
    end
  endgenerate

  // =====================================================================
  // Port B output multiplexer
  // A disabled modulator hands pin 2 back to plain I/O even if its select is set
  wire logic next_pin2 = (pin2_output_select && modulator_enable) ? chan_pulse[0] : gpio_pin2_i;
  // Pin 5 shows the idle-low channel while the modulator is stopped
  wire logic next_pin5 = pin5_output_select ? chan_pulse[1] : gpio_pin5_i;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin2_o <= 1'b0;
      pin5_o <= 1'b0;
    end else begin
      pin2_o <= next_pin2;
      pin5_o <= next_pin5;
    end
  end

  // =====================================================================
  // Assertions
  a_div_by_one: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && modulator_clock_select == 3'h0) |-> tick
  ) else $error("tick missing with divide by one");

  a_div_by_four: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (tick && modulator_enable && modulator_clock_select == 3'h2)
      ##1 (modulator_enable && modulator_clock_select == 3'h2) [*4]
    |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3)
  ) else $error("divide by four tick spacing wrong");

  a_count_step: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && tick) ##1 modulator_enable
    |-> chan_count[0] == 16'(($past(chan_count[0]) + 16'h0001))
  ) else $error("channel counter did not advance on tick");

  a_count_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && !tick) ##1 modulator_enable |-> $stable(chan_count[1])
  ) else $error("channel counter moved without tick");

  a_stream_top: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && modulator_clock_select == 3'h0 && density_word_one == 16'h8000) [*3]
    |-> chan_pulse[0] != $past(chan_pulse[0])
  ) else $error("top stream does not toggle at half rate");

  a_zero_density: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (tick && density_word_one == 16'h0000) |=> !chan_pulse[0]
  ) else $error("zero density produced a pulse");

  a_never_full: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && tick && chan_count[0] == 16'hffff) ##1 modulator_enable
    |-> !chan_pulse[0]
  ) else $error("channel high across counter wrap");

  a_pin2_gpio: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !(pin2_output_select && modulator_enable) |=> pin2_o == $past(gpio_pin2_i)
  ) else $error("pin 2 not plain I/O");

  a_pin2_route: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (pin2_output_select && modulator_enable) |=> pin2_o == $past(chan_pulse[0])
  ) else $error("pin 2 not carrying channel one");

  a_pin5_route: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    pin5_output_select |=> pin5_o == $past(chan_pulse[1])
  ) else $error("pin 5 not carrying channel two");

  a_pin5_gpio: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !pin5_output_select |=> pin5_o == $past(gpio_pin5_i)
  ) else $error("pin 5 not plain I/O");

  a_dens2_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_fire && hit_d2h) |=> density2_high == $past(pwdata_i[7:0]) && $stable(density2_low)
  ) else $error("second density high byte write lost");

  a_apb_wait: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (acc_req && !pready_o) |=> pready_o ##1 !pready_o
  ) else $error("pready not a single cycle after one wait");

  // Bus answers stand one cycle and are zero in between
  a_idle_quiet: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !pready_o |-> prdata_o == 32'h0000_0000 && !pslverr_o
  ) else $error("bus answer outside its cycle");

  a_slverr_map: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (acc_req && !pready_o) |=> pslverr_o != $past(hit_any)
  ) else $error("error response does not match the map");

  a_strobe_drop: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (acc_done && pwrite_i && !pstrb_i[0]) |=> $stable(density1_high) && $stable(port_b_mode)
  ) else $error("write without low strobe changed a register");

  a_mode_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_fire && hit_mode) |=> port_b_mode == ($past(pwdata_i[7:0]) & `PDM_MASK_PORT_B_MODE)
  ) else $error("port B mode write lost");

  a_dens1_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (wr_fire && hit_d1l) |=> density1_low == $past(pwdata_i[7:0]) && $stable(density1_high)
  ) else $error("first density low byte write lost");

  a_pulse_hold: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (modulator_enable && !tick) ##1 modulator_enable |-> $stable(chan_pulse[0])
  ) else $error("channel one changed between ticks");

  a_chan_stopped: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !modulator_enable |=> chan_count[0] == 16'h0000 && chan_count[1] == 16'h0000 && chan_pulse == 2'b00
  ) else $error("channels run while disabled");

  a_pin5_stopped: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (!modulator_enable && !$past(modulator_enable) && pin5_output_select) |=> !pin5_o
  ) else $error("pin 5 high while the modulator is stopped");

endmodule

`default_nettype wire

// ### pdm_modulator_tb.sv
// Self-checking testbench of the two-channel pulse density modulator
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module pdm_modulator_tb;
  typedef struct packed {
    logic [31:0] d;
    logic        e;
  } pdm_exp_type;

  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'h0;
  logic        gpio_pin2_i = 1'b0;
  logic        gpio_pin5_i = 1'b0;
  logic        pready_o;
  logic [31:0] prdata_o;
  logic        pslverr_o;
  logic        pin2_o;
  logic        pin5_o;
  int          n_fail = 0;
  int          compares = 0;
  int          h2;
  int          h5;
  int          r2;
  int          seed_ret;
  logic [15:0] dens2;
  pdm_exp_type exp_q[$];
  pdm_exp_type e;
  logic [7:0]  idx_tab[6] = '{8'h27, 8'h30, 8'h31, 8'h32, 8'h33, 8'h36};
  logic [7:0]  msk_tab[6] = '{8'h50, 8'hff, 8'hff, 8'hff, 8'hff, 8'h17};

  pdm_modulator u_pdm_modulator (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .pstrb_i     (pstrb_i),
    .pready_o    (pready_o),
    .prdata_o    (prdata_o),
    .pslverr_o   (pslverr_o),
    .gpio_pin2_i (gpio_pin2_i),
    .gpio_pin5_i (gpio_pin5_i),
    .pin2_o      (pin2_o),
    .pin5_o      (pin5_o)
  );

  always #5 clk_i = ~clk_i;

  // =====================================================================
  // Closing
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // =====================================================================
  // APB master; the expected answer is queued before the request starts
  task automatic apb(input bit wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] strb, input logic [7:0] ex, input logic er);
    exp_q.push_back('{d: {24'h000000, ex}, e: er});
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= {2'b00, idx, 2'b00};
    pwdata_i  <= {24'($urandom()), wd};
    pstrb_i   <= strb;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // No limit of its own: only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 4'hf, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic er);
    apb(1'b0, idx, 8'h00, 4'h0, ex, er);
  endtask

  // Answers are taken at the edge where pready is seen high
  always @(posedge clk_i) begin
    if (pready_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("MISMATCH t=%0t answer without request", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(prdata_o, e.d)
        `CHK(pslverr_o, e.e)
      end
    end
  end

  // =====================================================================
  // Pin helpers
  task automatic pins(input logic g2, input logic g5, input logic e2, input logic e5);
    gpio_pin2_i <= g2;
    gpio_pin5_i <= g5;
    repeat (3) @(posedge clk_i);
    `CHK(pin2_o, e2)
    `CHK(pin5_o, e5)
  endtask

  // Counts high cycles on both pins and rises on pin 2 over w cycles
  task automatic measure(input int w);
    logic p;
    h2 = 0;
    h5 = 0;
    r2 = 0;
    p = pin2_o;
    repeat (w) begin
      @(posedge clk_i);
      if (pin2_o === 1'b1) h2++;
      if (pin5_o === 1'b1) h5++;
      if (pin2_o === 1'b1 && p === 1'b0) r2++;
      p = pin2_o;
    end
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    seed_ret = $urandom(32'hfc9d);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // Reset values, writable masks, dropped writes and an unmapped place
    for (int i = 0; i < 6; i++) begin
      rd(idx_tab[i], 8'h00, 1'b0);
      wr(idx_tab[i], 8'hff);
      rd(idx_tab[i], msk_tab[i], 1'b0);
      wr(idx_tab[i], 8'h00);
      rd(idx_tab[i], 8'h00, 1'b0);
    end
    apb(1'b1, 8'h30, 8'ha5, 4'he, 8'h00, 1'b0);
    rd(8'h30, 8'h00, 1'b0);
    apb(1'b1, 8'h28, 8'h5a, 4'hf, 8'h00, 1'b1);
    rd(8'h28, 8'h00, 1'b1);
    // Pins stay plain I/O while no route is selected
    for (int i = 0; i < 4; i++) begin
      h2 = $urandom_range(3, 0);
      pins(h2[0], h2[1], h2[0], h2[1]);
    end
    // Routes selected but modulator off: pin 2 stays I/O, pin 5 is low
    wr(8'h27, 8'h50);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    wr(8'h27, 8'h00);
    // Bring-up order, then every divider code
    for (int c = 0; c < 8; c++) begin
      wr(8'h36, 8'h10);
      wr(8'h36, 8'h10 | c[7:0]);
      wr(8'h30, 8'h80);
      wr(8'h31, 8'h00);
      wr(8'h32, 8'h40);
      wr(8'h33, 8'h00);
      gpio_pin2_i <= 1'b1;
      gpio_pin5_i <= 1'b1;
      wr(8'h27, 8'h50);
      repeat ((4 << c) + 4) @(posedge clk_i);
      measure(32 << c);
      `CHK(h2, 16 << c)
      `CHK(r2, 16)
      `CHK(h5, 8 << c)
      wr(8'h27, 8'h00);
    end
    // Stream combination over a whole period of bits 12..3
    wr(8'h36, 8'h10);
    wr(8'h30, 8'h12);
    wr(8'h31, 8'h28);
    wr(8'h32, 8'h60);
    wr(8'h33, 8'h00);
    wr(8'h27, 8'h50);
    repeat (8) @(posedge clk_i);
    measure(8192);
    `CHK(h2, 32'h1228 / 8)
    `CHK(h5, 32'h6000 / 8)
    // Largest word never gives a steady high; random word on channel two
    dens2 = 16'($urandom());
    wr(8'h30, 8'hff);
    wr(8'h31, 8'hff);
    wr(8'h32, dens2[15:8]);
    wr(8'h33, dens2[7:0]);
    repeat (8) @(posedge clk_i);
    measure(65536);
    `CHK(h2, 65535)
    `CHK(h5, int'(dens2))
    // A zero word on a slow divider leaves channel one low
    wr(8'h36, 8'h13);
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h00);
    repeat (12) @(posedge clk_i);
    measure(64);
    `CHK(h2, 0)
    // Switching off returns pin 2 to I/O and stops channel two
    wr(8'h36, 8'h00);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    // Reset after switching off clears the pin routes and the registers
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd(8'h27, 8'h00, 1'b0);
    rd(8'h32, 8'h00, 1'b0);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    repeat (4) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end

  // Watchdog, above the expected run of about 84k cycles
  initial begin
    repeat (95000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule

`default_nettype wire
